// *** design/cesr_status.sv ***
// Crypto engine status register with event interrupts.
`timescale 1ns/1ps
`include "cesr_cfg.svh"
module cesr_status
    import cesr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Engine side
    input wire cesr_err_t err_in,
    input wire logic [3:0] proc_state,
    input wire logic dma_start,
    // Register port
    input wire logic [`CESR_ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------------------
    // Status capture
    // ------------------------------------------------------------------------
    logic [2:0] err_mode, next_err_mode;
    logic [2:0] err_op, next_err_op;
    logic [1:0] err_phase, next_err_phase;
    logic [3:0] state, next_state;
    logic started, next_started;
    logic [3:0] prev_state, next_prev_state;

    // The processor state is registered so the readback is one coherent snapshot.
    always_comb begin
        next_err_mode = err_mode;
        next_err_op = err_op;
        next_err_phase = err_phase;
        if (err_in.valid) begin
            next_err_mode = err_in.mode;
            next_err_op = err_in.op;
            next_err_phase = err_in.phase;
        end
        next_state = proc_state;
        next_prev_state = state;
        next_started = started | dma_start;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            err_mode <= 3'h0;
            err_op <= 3'h0;
            err_phase <= 2'h0;
            state <= 4'h0;
            prev_state <= 4'h0;
            started <= 1'b0;
        end else begin
            err_mode <= next_err_mode;
            err_op <= next_err_op;
            err_phase <= next_err_phase;
            state <= next_state;
            prev_state <= next_prev_state;
            started <= next_started;
        end
    end

    function automatic logic [31:0] status_word(input logic [2:0] m, input logic [2:0] o,
                                                input logic [1:0] p, input logic [3:0] s,
                                                input logic st);
        logic [31:0] w;
        w = `CESR_ZERO32;
        w[`CESR_MODE_LSB +: 3] = m;
        w[`CESR_OP_LSB +: 3] = o;
        w[`CESR_PHASE_LSB +: 2] = p;
        w[`CESR_STATE_LSB +: 4] = s;
        w[`CESR_START_BIT] = st;
        return w;
    endfunction

    // ------------------------------------------------------------------------
    // Interrupt bits
    // ------------------------------------------------------------------------
    logic [`CESR_IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [`CESR_IRQ_W-1:0] irq_en, next_irq_en;
    logic next_irq;
    logic [`CESR_IRQ_W-1:0] ev;

    always_comb begin
        ev = '0;
        ev[`CESR_IRQ_ERR] = err_in.valid;
        ev[`CESR_IRQ_START] = dma_start;
        ev[`CESR_IRQ_DONE] = (state == CESR_ST_DONE) && (prev_state != CESR_ST_DONE);
        next_irq_stat = irq_stat;
        next_irq_en = irq_en;
        if (wr && addr == `CESR_OFS_IRQ_CLR) begin
            next_irq_stat = irq_stat & ~wdata[`CESR_IRQ_W-1:0];
        end
        // A new event wins over a clear in the same cycle.
        next_irq_stat = next_irq_stat | ev;
        if (wr && addr == `CESR_OFS_IRQ_EN) begin
            next_irq_en = wdata[`CESR_IRQ_W-1:0];
        end
        next_irq = |(next_irq_stat & next_irq_en);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_stat <= '0;
            irq_en <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            irq <= next_irq;
        end
    end

    // ------------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------------
    // Writes to the status offset fall through with no effect.
    logic [31:0] next_rdata;

    always_comb begin
        next_rdata = `CESR_ZERO32;
        if (rd) begin
            unique case (addr)
                `CESR_OFS_STATUS: begin
                    next_rdata = status_word(err_mode, err_op, err_phase, state, started);
                end
                `CESR_OFS_IRQ_STAT: begin
                    next_rdata[`CESR_IRQ_W-1:0] = irq_stat;
                end
                `CESR_OFS_IRQ_EN: begin
                    next_rdata[`CESR_IRQ_W-1:0] = irq_en;
                end
                default: begin
                    next_rdata = `CESR_ZERO32;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= `CESR_ZERO32;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule

// *** design/cesr_cfg.svh ***
// Constants for the crypto engine status report block.
// ----------------------------------------------------------------------------
// Summary of operation
// - Bits 31-29 give error context: normal, preboot, key-wrap, content-key; rest reserved.
// - Bits 28-26 give failing operation: 001 encrypt, 010 decrypt, 100 authenticate.
// - Bits 25-24 give DMA access phase at error: descriptor, association, source, dest.
// - Bits 21-18 show descriptor processor state, codes 0 to 6 used.
// - Bit 17 sets once a DMA start occurred, clear before any start.
// - Bits 23-22 always read as zero.
// ----------------------------------------------------------------------------
`ifndef CESR_CFG_SVH
`define CESR_CFG_SVH
`define CESR_ADDR_W 4
`define CESR_OFS_STATUS 4'h0
`define CESR_OFS_IRQ_STAT 4'h4
`define CESR_OFS_IRQ_CLR 4'h8
`define CESR_OFS_IRQ_EN 4'hC
`define CESR_MODE_LSB 29
`define CESR_OP_LSB 26
`define CESR_PHASE_LSB 24
`define CESR_STATE_LSB 18
`define CESR_START_BIT 17
`define CESR_IRQ_ERR 0
`define CESR_IRQ_START 1
`define CESR_IRQ_DONE 2
`define CESR_IRQ_W 3
`define CESR_ZERO32 32'h0000_0000
`endif

// *** design/cesr_pkg.sv ***
// Types shared by the crypto engine status report block.
package cesr_pkg;
    typedef enum logic [2:0] {
        CESR_CTX_NORMAL = 3'h0,
        CESR_CTX_PREBOOT = 3'h1,
        CESR_CTX_KEY_WRAP = 3'h2,
        CESR_CTX_CONTENT_KEY = 3'h3
    } cesr_ctx_t;
    typedef enum logic [2:0] {
        CESR_OP_NONE = 3'h0,
        CESR_OP_ENCRYPT = 3'h1,
        CESR_OP_DECRYPT = 3'h2,
        CESR_OP_AUTH = 3'h4
    } cesr_op_t;
    typedef enum logic [1:0] {
        CESR_PH_DESCRIPTOR = 2'h0,
        CESR_PH_ASSOCIATION = 2'h1,
        CESR_PH_SOURCE = 2'h2,
        CESR_PH_DEST = 2'h3
    } cesr_phase_t;
    typedef enum logic [3:0] {
        CESR_ST_IDLE = 4'h0,
        CESR_ST_FETCH_PENDING = 4'h1,
        CESR_ST_LOADING = 4'h2,
        CESR_ST_DATA = 4'h3,
        CESR_ST_DONE = 4'h4,
        CESR_ST_FETCH_OFF = 4'h5,
        CESR_ST_ASSOC_FETCH = 4'h6
    } cesr_state_t;
    // Error capture from the engine: one-cycle strobe plus its context.
    typedef struct packed {
        logic valid;
        logic [2:0] mode;
        logic [2:0] op;
        logic [1:0] phase;
    } cesr_err_t;
endpackage

// *** tb/cesr_status_assertions.sv ***
// Port assertions for the crypto engine status register.
`timescale 1ns/1ps
module cesr_chk import cesr_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire cesr_err_t err_in,
    input wire logic [3:0] proc_state,
    input wire logic dma_start,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic irq
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
mode_a: assert property (rd && addr == 4'h0 && $past(err_in.valid)
    |=> rdata[31:29] == $past(err_in.mode, 2)) else $error("mode");
op_a: assert property (rd && addr == 4'h0 && $past(err_in.valid)
    |=> rdata[28:26] == $past(err_in.op, 2)) else $error("op");
phase_a: assert property (rd && addr == 4'h0 && $past(err_in.valid)
    |=> rdata[25:24] == $past(err_in.phase, 2)) else $error("phase");
state_a: assert property (rd && addr == 4'h0
    |=> rdata[21:18] == $past(proc_state, 2)) else $error("state");
start_a: assert property (dma_start ##1 rd && addr == 4'h0 |=> rdata[17])
    else $error("start");
gap_a: assert property (rd |=> rdata[23:22] == 2'h0) else $error("gap");
reset_a: assert property ($fell(rst) |-> rdata == 32'h0 && !irq)
    else $error("reset");
idle_a: assert property (!rd |=> rdata == 32'h0) else $error("idle");
cover property (rd && addr == 4'h0 && $past(err_in.valid));
cover property (irq);
cover property (wr && addr == 4'h8);
endmodule
bind cesr_status cesr_chk chk_u (.*);

// *** tb/test_cesr_status.sv ***
// Self-checking bench for the crypto engine status register.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end end
module test_cesr_status import cesr_pkg::*;
;
logic clk = 0, rst = 1, dma_start = 0, wr = 0, rd = 0, irq, q, started = 0;
cesr_err_t err_in = '0;
logic [3:0] proc_state = 0, addr = 0;
logic [31:0] wdata = 0, rdata, d, seed = 32'h08619459;
logic [2:0] ops [3] = '{3'h1, 3'h2, 3'h4};
int num_errors = 0, n_compared = 0;
always #10 clk = ~clk;
cesr_status dut_u (.clk(clk), .rst(rst), .err_in(err_in), .proc_state(proc_state),
    .dma_start(dma_start), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));
function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
endfunction
function automatic logic [31:0] exp_st(int i, logic b);
    return {3'(i % 4), ops[i % 3], 2'(i % 4), 2'h0, 4'(i), b, 17'h0};
endfunction
task automatic wreg(logic [3:0] a, logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
endtask
// Read data stand for one cycle only, so they are sampled just after the edge.
task automatic rreg(logic [3:0] a);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 d = rdata;
    q = irq;
    @(posedge clk);
endtask
task automatic give_verdict();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask
initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rreg(4'h0);
    `CHK("status", 32'h0, d)
    for (int i = 0; i < 7; i++) begin
        seed = xs(seed);
        err_in <= '{1'h1, 3'(i % 4), ops[i % 3], 2'(i % 4)};
        proc_state <= 4'(i);
        dma_start <= i == 3 || (i > 0 && seed[0]);
        started |= i == 3 || (i > 0 && seed[0]);
        @(posedge clk);
        err_in <= '0;
        dma_start <= 1'h0;
        rreg(4'h0);
        `CHK("status", exp_st(i, started), d)
        wreg(4'h0, seed);
    end
    wreg(4'hC, 32'h7);
    rreg(4'h4);
    `CHK("irq_stat", 32'h7, d)
    `CHK("irq", 1'h1, q)
    wreg(4'h8, 32'h7);
    wreg(4'hC, 32'h0);
    dma_start <= 1'h1;
    @(posedge clk);
    dma_start <= 1'h0;
    rreg(4'h4);
    `CHK("irq_stat", 32'h2, d)
    `CHK("irq", 1'h0, q)
    rreg(4'h2);
    `CHK("unmapped", 32'h0, d)
    give_verdict();
end
initial begin
    #100000;
    num_errors++;
    give_verdict();
end
endmodule
